// ===== hw/pio_pkg.sv
// shared constants and types for the pin io element
package pio_pkg;
  // ***************************************************
  // operating modes
  // ***************************************************
  typedef enum logic [1:0] {
    PIO_SDR,
    PIO_DDR_IN,
    PIO_DDR_OUT,
    PIO_DDR_BIDIR
  } pio_mode_t;

  // ***************************************************
  // sizes and settings
  // ***************************************************
  localparam int PIO_PCB_SIGNALS = 6;
  localparam int PIO_PCB_IDX_W   = 3;
  localparam int PIO_DELAY_LEVELS = 3;
  localparam logic [1:0] PIO_DELAY_OFF = 2'h0;
  localparam int PIO_FIFO_DEPTH  = 16;
  localparam int PIO_PAIR_W      = 2;
  localparam logic PIO_VALID_RST = 1'b0;
endpackage

// ===== hw/pio_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pio_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } pio_fifo_st_t;

  pio_fifo_st_t           s_q;
  pio_fifo_st_t           s_d;
  logic [WIDTH-1:0]       mem_q [DEPTH];
  logic                   push;
  logic                   pop;

  // ***************************************************
  // flags and pointers
  // ***************************************************
  assign wr_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign rd_valid = (s_q.cnt != '0);
  assign rd_data  = mem_q[s_q.rp];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage has no reset; only the pointers matter
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[s_q.wp] <= wr_data;
    end
  end
endmodule

// ===== hw/pio_element.sv
// pin io element: sdr and ddr registers, control bus select, input delay
//
// Contract
// RULE1: twelve control signals, six oe and six ce, from core or fast lines.
// RULE2: six registers; ddr input, ddr output and bidirectional ddr modes.
// RULE3: one shared clear or preset source used by every register.
// RULE4: registers power up to programmed level; low uses clear, high preset. Here rx_valid always resets low.
// RULE5: ddr input captures on rising edge into one, falling into the other.
// RULE6: latch holds high-time data so both bits align to one edge.
// RULE7: two output registers load on rising edges, clock muxes them out.
// RULE8: first register drives pin while clock high, second while low.
// RULE9: input to core delay selectable: off or three increasing levels.
// RULE10: bidir ddr adds registered oe; input captured only while undriven.
`timescale 1ns/1ps
module pio_element
  import pio_pkg::*;
#(
  parameter bit POWERUP_HIGH = 1'b0,
  parameter bit CLR_PRE_EN   = 1'b1,
  parameter int FIFO_DEPTH   = pio_pkg::PIO_FIFO_DEPTH,
  parameter int PCB_SIGNALS  = pio_pkg::PIO_PCB_SIGNALS
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  input  wire logic                          clr_pre_n,
  input  wire pio_pkg::pio_mode_t            mode,
  input  wire logic [PCB_SIGNALS-1:0]        core_oe,
  input  wire logic [PCB_SIGNALS-1:0]        core_ce,
  input  wire logic [PCB_SIGNALS-1:0]        fast_oe,
  input  wire logic [PCB_SIGNALS-1:0]        fast_ce,
  input  wire logic [2*PCB_SIGNALS-1:0]      pcb_fast_sel,
  input  wire logic [pio_pkg::PIO_PCB_IDX_W-1:0] oe_idx,
  input  wire logic [pio_pkg::PIO_PCB_IDX_W-1:0] ce_in_idx,
  input  wire logic [pio_pkg::PIO_PCB_IDX_W-1:0] ce_out_idx,
  input  wire logic [1:0]                    in_delay_sel,
  input  wire logic [pio_pkg::PIO_PAIR_W-1:0] tx_data,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  output logic [pio_pkg::PIO_PAIR_W-1:0]     rx_data,
  output logic                               rx_valid,
  output logic                               core_in,
  input  wire logic                          pad_in,
  output logic                               pad_out,
  output logic                               pad_oe
);
  import pio_pkg::*;

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic                        in_rise;
    logic                        out_first;
    logic                        out_second;
    logic                        oe;
    logic [PIO_PAIR_W-1:0]       pair;
    logic                        rx_valid;
    logic [PIO_DELAY_LEVELS-1:0] dly;
  } pio_pos_st_t;

  typedef struct packed {
    logic in_fall;
    logic in_latch;
  } pio_neg_st_t;

  localparam logic PU = POWERUP_HIGH;
  localparam pio_pos_st_t POS_RST = '{
    in_rise:    PU,
    out_first:  PU,
    out_second: PU,
    oe:         PU,
    pair:       {PIO_PAIR_W{PU}},
    rx_valid:   PIO_VALID_RST,
    dly:        {PIO_DELAY_LEVELS{PU}}
  };
  localparam pio_neg_st_t NEG_RST = '{in_fall: PU, in_latch: PU};

  pio_pos_st_t             p_q;
  pio_pos_st_t             p_d;
  pio_neg_st_t             n_q;
  pio_neg_st_t             n_d;
  logic                    arst_n;
  logic                    oe_src;
  logic                    ce_in;
  logic                    ce_out;
  logic [PIO_PAIR_W-1:0]   fifo_data;
  logic                    fifo_valid;
  logic                    take;
  logic                    capture_ok;

  // ***************************************************
  // shared clear or preset
  // ***************************************************
  // one source for all reset registers; the level is fixed by the power-up choice except rx_valid and the fifo pointers and count, which reset low
  assign arst_n = reset_n & (clr_pre_n | ~CLR_PRE_EN); // [RULE3] [RULE4]

  // ***************************************************
  // peripheral control bus select
  // ***************************************************
  assign oe_src = pcb_fast_sel[oe_idx] ? fast_oe[oe_idx]
                                       : core_oe[oe_idx]; // [RULE1]
  assign ce_in  = pcb_fast_sel[PCB_SIGNALS + ce_in_idx] ? fast_ce[ce_in_idx]
                                       : core_ce[ce_in_idx]; // [RULE1]
  assign ce_out = pcb_fast_sel[PCB_SIGNALS + ce_out_idx] ? fast_ce[ce_out_idx]
                                       : core_ce[ce_out_idx]; // [RULE1]

  // ***************************************************
  // transmit buffer
  // ***************************************************
  pio_fifo #(
    .WIDTH (PIO_PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .wr_data  (tx_data),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .rd_data  (fifo_data),
    .rd_valid (fifo_valid),
    .rd_ready (take)
  );

  // output path stalls on ce low, which backs the fifo up to the core
  assign take = ce_out & fifo_valid & (mode != PIO_DDR_IN);

  // bidir: the pin is only sampled while our driver is off
  assign capture_ok = (mode != PIO_DDR_OUT) &&
                      !((mode == PIO_DDR_BIDIR) && p_q.oe); // [RULE10]

  // ***************************************************
  // rising edge logic
  // ***************************************************
  always_comb begin
    p_d = p_q;
    p_d.dly = {p_q.dly[PIO_DELAY_LEVELS-2:0], pad_in}; // [RULE9]
    if (ce_in) begin
      p_d.in_rise = pad_in; // [RULE5]
    end
    if (take) begin
      p_d.out_first  = fifo_data[1]; // [RULE7]
      p_d.out_second = fifo_data[0]; // [RULE7]
    end
    p_d.oe = (mode == PIO_DDR_IN) ? 1'b0 : oe_src; // [RULE10]
    p_d.rx_valid = ce_in & capture_ok;
    if (ce_in && capture_ok) begin
      case (mode)
        PIO_SDR: begin
          p_d.pair = {1'b0, p_q.in_rise};
        end
        PIO_DDR_IN, PIO_DDR_BIDIR: begin
          p_d.pair = {n_q.in_latch, n_q.in_fall}; // [RULE6] [RULE2]
        end
        default: begin
          p_d.pair = p_q.pair;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      p_q <= POS_RST; // [RULE4]
    end else begin
      p_q <= p_d;
    end
  end

  // ***************************************************
  // falling edge logic
  // ***************************************************
  // the latch keeps the bit taken at the rising edge through the low phase
  always_comb begin
    n_d = n_q;
    n_d.in_fall  = pad_in;    // [RULE5]
    n_d.in_latch = p_q.in_rise; // [RULE6]
  end

  always_ff @(negedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_q <= NEG_RST; // [RULE4]
    end else begin
      n_q <= n_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign rx_data  = p_q.pair;
  assign rx_valid = p_q.rx_valid;
  assign pad_oe   = p_q.oe;

  // clock muxes the two registers except in sdr mode; glitch free only with matched paths
  assign pad_out = (mode == PIO_SDR) ? p_q.out_first
                 : (ref_clk ? p_q.out_first : p_q.out_second); // [RULE8]

  // delays are whole cycles here, a coarse stand-in for the delay chain
  always_comb begin
    case (in_delay_sel)
      PIO_DELAY_OFF: core_in = pad_in; // [RULE9]
      2'h1:          core_in = p_q.dly[0];
      2'h2:          core_in = p_q.dly[1];
      default:       core_in = p_q.dly[2];
    endcase
  end
endmodule

// ===== verification/pio_element_properties.sv
// assertion checker for the pin io element ports
`timescale 1ns/1ps
module pio_element_properties
  import pio_pkg::*;
#(
  parameter bit POWERUP_HIGH = 1'b0,
  parameter bit CLR_PRE_EN   = 1'b1
) (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic               clr_pre_n,
  input wire pio_pkg::pio_mode_t mode,
  input wire logic [1:0]         in_delay_sel,
  input wire logic [1:0]         rx_data,
  input wire logic               rx_valid,
  input wire logic               core_in,
  input wire logic               pad_in,
  input wire logic               pad_out,
  input wire logic               pad_oe
);
  logic fall_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ********
  // falling-edge pin copy rebuilds the expected pair
  // ********
  always_ff @(negedge ref_clk) fall_q <= pad_in;
  property p_rst; disable iff (1'b0)
    !reset_n |-> pad_oe == POWERUP_HIGH && !rx_valid; endproperty
  a_rst: assert property (p_rst) else $error("reset level");
  property p_clr; CLR_PRE_EN && !clr_pre_n |->
    pad_oe == POWERUP_HIGH && pad_out == POWERUP_HIGH; endproperty
  a_clr: assert property (p_clr) else $error("clear level");
  property p_sdr; mode == PIO_SDR && $past(mode, 2) == PIO_SDR && rx_valid
    |-> rx_data == {1'b0, $past(pad_in, 2)}; endproperty
  a_sdr: assert property (p_sdr) else $error("sdr capture");
  property p_ddr; mode == PIO_DDR_IN && $past(mode, 2) == PIO_DDR_IN &&
    rx_valid |-> rx_data == {$past(pad_in, 2), $past(fall_q)}; endproperty
  a_ddr: assert property (p_ddr) else $error("ddr pair");
  property p_out_rx; mode == PIO_DDR_OUT && $past(mode, 2) == PIO_DDR_OUT
    |-> !rx_valid; endproperty
  a_out_rx: assert property (p_out_rx) else $error("rx in out mode");
  property p_bidir; mode == PIO_DDR_BIDIR && $past(pad_oe) &&
    $past(mode, 2) == PIO_DDR_BIDIR |-> !rx_valid; endproperty
  a_bidir: assert property (p_bidir) else $error("rx driving");
  property p_dly0; in_delay_sel == 2'h0 |-> core_in == pad_in; endproperty
  a_dly0: assert property (p_dly0) else $error("direct input");
  property p_dly1; in_delay_sel == 2'h1 && $past(reset_n) && clr_pre_n &&
    $past(clr_pre_n) |-> core_in == $past(pad_in); endproperty
  a_dly1: assert property (p_dly1) else $error("first delay");
  property p_dly2; in_delay_sel == 2'h2 && $past(reset_n, 2) && clr_pre_n
    && $past(clr_pre_n) && $past(clr_pre_n, 2)
    |-> core_in == $past(pad_in, 2); endproperty
  a_dly2: assert property (p_dly2) else $error("second delay");
  property p_dly3; in_delay_sel == 2'h3 && $past(in_delay_sel, 3) == 2'h3
    && $past(reset_n, 3) |-> core_in == $past(pad_in, 3); endproperty
  a_dly3: assert property (p_dly3) else $error("third delay");
endmodule

// ===== verification/pio_pin_model.sv
// pin-side partner: drives ddr data in, captures both output phases
`timescale 1ns/1ps
module pio_pin_model (
  input  wire logic ref_clk,
  input  wire logic pad_out,
  input  wire logic pad_oe,
  output logic      pad_in,
  output logic      got_hi,
  output logic      got_lo
);
  logic [7:0] pat_q = 8'h4b;
  // ********
  // quarter-period timing keeps pin changes clear of both edges
  // ********
  always @(ref_clk) begin
    #25;
    pat_q = {pat_q[6:0], pat_q[7] ^ pat_q[5]};
    if (ref_clk)
      got_hi = pad_out;
    else
      got_lo = pad_out;
  end
  // the element owns the wire while it drives
  assign pad_in = pad_oe ? pad_out : pat_q[0];
endmodule

// ===== verification/pio_element_tb_top.sv
// self-checking bench for the pin io element
`timescale 1ns/1ps
module pio_element_tb_top;
  import pio_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n, clr_pre_n, tx_valid, tx_ready, rx_valid, ok;
  logic        core_in, pad_in, pad_out, pad_oe, got_hi, got_lo;
  pio_mode_t   mode;
  logic [5:0]  core_oe, core_ce, fast_oe, fast_ce;
  logic [11:0] pcb_fast_sel;
  logic [2:0]  oe_idx, ce_in_idx, ce_out_idx;
  logic [1:0]  in_delay_sel, tx_data, rx_data;
  int          checks = 0, mismatches = 0, n;
  always #50 ref_clk = ~ref_clk;
  pio_element dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .clr_pre_n(clr_pre_n), .mode(mode), .core_oe(core_oe), .core_ce(core_ce),
    .fast_oe(fast_oe), .fast_ce(fast_ce), .pcb_fast_sel(pcb_fast_sel),
    .oe_idx(oe_idx), .ce_in_idx(ce_in_idx), .ce_out_idx(ce_out_idx),
    .in_delay_sel(in_delay_sel), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  pio_pin_model pin_u (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_in(pad_in), .got_hi(got_hi), .got_lo(got_lo));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cnt_rx(int k);
    n = 0;
    repeat (k) begin
      @(negedge ref_clk);
      if (rx_valid === 1'b1) n++;
    end
  endtask
  // valid stays up between pushes; callers drop it
  task automatic push(logic [1:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    ok = tx_ready;
    @(negedge ref_clk);
  endtask
  task automatic t_out();
    mode = PIO_DDR_OUT;
    core_ce = 6'h04;
    ce_out_idx = 3'h2;
    // input side enabled too, so only the mode can keep rx quiet
    ce_in_idx = 3'h2;
    for (int v = 0; v < 4; v++) begin
      push(v[1:0]);
      tx_valid = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("pad pair", v[7:0], {6'h00, got_hi, got_lo});
    end
  endtask
  task automatic t_fill();
    ce_out_idx = 3'h3;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      push(i[1:0]);
      if (ok === 1'b1) n++;
    end
    tx_valid = 1'b0;
    chk("fifo room", 8'h10, n[7:0]);
    pcb_fast_sel = 12'h200;
    fast_ce = 6'h08;
    repeat (20) @(negedge ref_clk);
    chk("drained", 8'h07, {5'h00, tx_ready, got_hi, got_lo});
  endtask
  task automatic t_rx();
    mode = PIO_DDR_IN;
    ce_in_idx = 3'h1;
    core_ce = 6'h02;
    repeat (3) @(negedge ref_clk);
    cnt_rx(8);
    chk("ddr in pulses", 8'h08, n[7:0]);
    core_ce = 6'h00;
    repeat (2) @(negedge ref_clk);
    cnt_rx(8);
    chk("gated pulses", 8'h00, n[7:0]);
    mode = PIO_DDR_BIDIR;
    core_ce = 6'h02;
    core_oe = 6'h01;
    repeat (3) @(negedge ref_clk);
    cnt_rx(8);
    chk("driving pulses", 8'h80, {pad_oe, n[6:0]});
    clr_pre_n = 1'b0;
    @(negedge ref_clk);
    chk("clear level", 8'h00, {6'h00, pad_oe, pad_out});
    clr_pre_n = 1'b1;
    core_oe = 6'h00;
    repeat (3) @(negedge ref_clk);
    cnt_rx(8);
    chk("bidir idle pulses", 8'h08, n[7:0]);
  endtask
  task automatic t_dly();
    mode = PIO_SDR;
    for (int k = 3; k >= 0; k--) begin
      in_delay_sel = k[1:0];
      repeat (6) @(negedge ref_clk);
    end
    chk("direct input", {7'h00, pad_in}, {7'h00, core_in});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(2000 * 100);
    mismatches++;
    wrap_up();
  end
  initial begin
    reset_n = 1'b0;
    clr_pre_n = 1'b1;
    mode = PIO_SDR;
    {core_oe, core_ce, fast_oe, fast_ce} = 24'h000000;
    pcb_fast_sel = 12'h000;
    {oe_idx, ce_in_idx, ce_out_idx} = 9'h000;
    {in_delay_sel, tx_data, tx_valid} = 5'h00;
    repeat (16) @(negedge ref_clk);
    chk("reset outputs", 8'h02, {5'h00, pad_oe, tx_ready, rx_valid});
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_out();
    t_fill();
    t_rx();
    t_dly();
    wrap_up();
  end
endmodule
bind pio_element pio_element_properties #(.POWERUP_HIGH(POWERUP_HIGH),
  .CLR_PRE_EN(CLR_PRE_EN)) chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
  .clr_pre_n(clr_pre_n), .mode(mode), .in_delay_sel(in_delay_sel),
  .rx_data(rx_data), .rx_valid(rx_valid), .core_in(core_in),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
